/* shared/hms_pkg.sv */
// constants and types for the halt mode sequencer
package hms_pkg;
  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_OPTION = 8'h10;
  // control register fields
  localparam int CTRL_OSC_IRQ_ENABLE = 0;
  // option register fields
  localparam int OPT_LONG_DELAY = 0;
  localparam int OPT_WDG_HALT = 1;
  // interrupt status fields
  localparam int IRQ_ENTER = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_WDG_RESET = 2;
  localparam int IRQ_BITS = 3;
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] OPTION_RESET = 32'h0000_0000;
  // halt opcode and mask level forced on entry
  localparam logic [7:0] HALT_OPCODE = 8'h8e;
  localparam logic [1:0] MASK_LEVEL_ENABLE = 2'h2;
  // settling delay lengths in cpu cycles
  localparam int SETTLE_SHORT = 256;
  localparam int SETTLE_LONG = 4096;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    HMS_RUN,
    HMS_TIMED_SLEEP,
    HMS_FULL_HALT,
    HMS_SETTLE
  } hms_state_t;
endpackage

/* logic/hms_sequencer.sv */
// halt mode sequencer: timed deep sleep and full halt with axi4-lite registers
// What this block does
// - halt with osc_irq_enable set enters timed deep sleep
// - timed deep sleep wakes only on timebase interrupt or reset
// - timebase wake resumes cpu at once, no settling delay
// - reset wake from timed deep sleep applies settling delay first
// - entry to either state forces mask level to binary 10
// - timed deep sleep keeps only oscillator and timebase clocked
// - timed deep sleep with osc_irq_enable set never resets via watchdog
// - settling delay length is 256 or 4096 cycles by option
// - halt with osc_irq_enable clear enters full halt
// - full halt wakes on reset or halt-capable interrupt, then settles
// - after settling release cpu to interrupt or reset vector
// - full halt stops oscillator and all peripheral clocks
// - watchdog halt option decides if halt gives watchdog reset
// - waking interrupt service pushes condition code, sets level, pops restore
// - opcode 0x8e decodes as the halt instruction
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module hms_sequencer
  import hms_pkg::*;
#(
  parameter int SHORT_DELAY = SETTLE_SHORT,
  parameter int LONG_DELAY = SETTLE_LONG
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // cpu core
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  input wire logic wake_reset,
  input wire logic timebase_irq,
  input wire logic halt_wake_irq,
  input wire logic watchdog_active,
  input wire logic irq_service,
  input wire logic [1:0] irq_level,
  input wire logic cc_pop,
  input wire logic [1:0] cc_popped_level,
  output logic [1:0] mask_level,
  output logic cc_push,
  output logic cpu_run,
  output logic fetch_reset_vector,
  // clock gating
  output logic osc_enable,
  output logic timebase_clk_en,
  output logic periph_clk_en,
  output logic watchdog_reset,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq
);
  localparam int CW = $clog2(LONG_DELAY + 1);
  localparam logic [CW-1:0] SHORT_TERM = CW'(SHORT_DELAY - 1);
  localparam logic [CW-1:0] LONG_TERM = CW'(LONG_DELAY - 1);

  // the counter width follows the long delay, so the short one may not exceed it
  if (SHORT_DELAY < 1 || LONG_DELAY < SHORT_DELAY) begin : gen_bad_delay
    $error("hms_sequencer: settling delays must satisfy 1 <= short <= long");
  end

  hms_state_t state;
  logic [CW-1:0] settle_count;
  logic settle_from_reset;
  logic osc_irq_enable;
  logic [1:0] option;
  logic [IRQ_BITS-1:0] irq_stat;
  logic [IRQ_BITS-1:0] irq_mask;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // halt is decoded only while the cpu runs
  logic halt_exec;
  logic [CW-1:0] settle_term;
  logic settle_done;
  logic wr_fire;
  logic ev_enter;
  logic ev_wake;
  logic ev_wdg;
  assign halt_exec = opcode_valid && opcode == HALT_OPCODE && cpu_run;
  assign settle_term = option[OPT_LONG_DELAY] ? LONG_TERM : SHORT_TERM;
  assign settle_done = settle_count == settle_term;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  // a halt turned into a watchdog reset is not an entry
  assign ev_enter = halt_exec && !ev_wdg;
  assign ev_wake = (state == HMS_TIMED_SLEEP && (timebase_irq || wake_reset))
    || (state == HMS_FULL_HALT && (halt_wake_irq || wake_reset));
  // watchdog reset only from full halt entry, never from timed sleep
  assign ev_wdg = halt_exec && !osc_irq_enable && watchdog_active && !option[OPT_WDG_HALT];

  // sequencer state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= HMS_RUN;
      settle_from_reset <= 1'b0;
    end else begin
      case (state)
        HMS_RUN: begin
          if (halt_exec && !ev_wdg) begin
            state <= osc_irq_enable ? HMS_TIMED_SLEEP : HMS_FULL_HALT;
          end
        end
        HMS_TIMED_SLEEP: begin
          if (wake_reset) begin
            state <= HMS_SETTLE;
            settle_from_reset <= 1'b1;
          end else if (timebase_irq) begin
            state <= HMS_RUN;
            settle_from_reset <= 1'b0;
          end
        end
        HMS_FULL_HALT: begin
          if (wake_reset || halt_wake_irq) begin
            state <= HMS_SETTLE;
            settle_from_reset <= wake_reset;
          end
        end
        HMS_SETTLE: begin
          if (settle_done) begin
            state <= HMS_RUN;
          end
        end
        default: state <= HMS_RUN;
      endcase
    end
  end

  // settling counter restarts from zero with the oscillator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_count <= '0;
    end else if (state == HMS_SETTLE && !settle_done) begin
      settle_count <= settle_count + 1'b1;
    end else begin
      settle_count <= '0;
    end
  end

  // clock gating and cpu release, registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_run <= 1'b1;
      osc_enable <= 1'b1;
      timebase_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      fetch_reset_vector <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= ev_wdg;
      fetch_reset_vector <= state == HMS_SETTLE && settle_done && settle_from_reset;
      if (halt_exec && !ev_wdg) begin
        cpu_run <= 1'b0;
        periph_clk_en <= 1'b0;
        osc_enable <= osc_irq_enable;
        timebase_clk_en <= osc_irq_enable;
      end else if (state == HMS_TIMED_SLEEP && (timebase_irq || wake_reset)) begin
        cpu_run <= !wake_reset;
        periph_clk_en <= !wake_reset;
      end else if (state == HMS_FULL_HALT && (wake_reset || halt_wake_irq)) begin
        osc_enable <= 1'b1;
        timebase_clk_en <= 1'b1;
      end else if (state == HMS_SETTLE && settle_done) begin
        cpu_run <= 1'b1;
        periph_clk_en <= 1'b1;
      end
    end
  end

  // interrupt mask level and condition code stacking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_level <= 2'h3;
      cc_push <= 1'b0;
    end else begin
      cc_push <= irq_service && cpu_run;
      if (halt_exec && !ev_wdg) begin
        mask_level <= MASK_LEVEL_ENABLE;
      end else if (irq_service && cpu_run) begin
        // the stacked copy lives in cpu memory; the core hands it back on pop
        mask_level <= irq_level;
      end else if (cc_pop) begin
        mask_level <= cc_popped_level;
      end
    end
  end

  // axi write channel capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == OFF_CTRL || aw_addr == OFF_IRQ_STAT || aw_addr == OFF_IRQ_MASK
            || aw_addr == OFF_OPTION || aw_addr == OFF_STATUS) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // software registers; status is read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_irq_enable <= CTRL_RESET[CTRL_OSC_IRQ_ENABLE];
      option <= OPTION_RESET[1:0];
      irq_mask <= '0;
    end else if (wr_fire && w_strb[0]) begin
      if (aw_addr == OFF_CTRL) begin
        osc_irq_enable <= w_data[CTRL_OSC_IRQ_ENABLE];
      end else if (aw_addr == OFF_IRQ_MASK) begin
        irq_mask <= w_data[IRQ_BITS-1:0];
      end else if (aw_addr == OFF_OPTION) begin
        option <= w_data[1:0];
      end
    end
  end

  // sticky events; a new event wins over a write-one clear
  logic [IRQ_BITS-1:0] ev_vec;
  logic [IRQ_BITS-1:0] clr_vec;
  assign ev_vec = {ev_wdg, ev_wake, ev_enter};
  assign clr_vec = (wr_fire && w_strb[0] && aw_addr == OFF_IRQ_STAT) ? w_data[IRQ_BITS-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~clr_vec) | ev_vec;
      irq <= |(((irq_stat & ~clr_vec) | ev_vec) & irq_mask);
    end
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == OFF_CTRL) begin
        s_axi_rdata <= {31'h0, osc_irq_enable};
      end else if (s_axi_araddr == OFF_STATUS) begin
        s_axi_rdata <= {24'h0, 1'b0, state, settle_from_reset, mask_level, cpu_run};
      end else if (s_axi_araddr == OFF_IRQ_STAT) begin
        s_axi_rdata <= {29'h0, irq_stat};
      end else if (s_axi_araddr == OFF_IRQ_MASK) begin
        s_axi_rdata <= {29'h0, irq_mask};
      end else if (s_axi_araddr == OFF_OPTION) begin
        s_axi_rdata <= {30'h0, option};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // checks
  chk_halt_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_exec && !ev_wdg |=> mask_level == MASK_LEVEL_ENABLE && !cpu_run)
    else $error("halt entry did not force mask level or stop cpu");
  chk_sleep_kind: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_exec && osc_irq_enable |=> state == HMS_TIMED_SLEEP && timebase_clk_en)
    else $error("timed sleep not entered");
  chk_full_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_exec && !osc_irq_enable && !ev_wdg |=> state == HMS_FULL_HALT && !osc_enable)
    else $error("full halt not entered with oscillator off");
  chk_sleep_only: assert property (@(posedge aclk) disable iff (!aresetn)
    state == HMS_TIMED_SLEEP && !timebase_irq && !wake_reset |=> state == HMS_TIMED_SLEEP)
    else $error("timed sleep left without timebase or reset");
  chk_fast_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    state == HMS_TIMED_SLEEP && timebase_irq && !wake_reset |=> state == HMS_RUN && cpu_run)
    else $error("timebase wake inserted a delay");
  chk_no_wdg_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_exec && osc_irq_enable |=> !watchdog_reset)
    else $error("watchdog reset from timed sleep");
  chk_settle_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    state == HMS_SETTLE && !settle_done |=> !cpu_run)
    else $error("cpu released before settling ended");
  chk_settle_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state == HMS_SETTLE) && !option[OPT_LONG_DELAY] |-> ##[1:300] state == HMS_RUN)
    else $error("short settling delay overran");
  chk_periph_off: assert property (@(posedge aclk) disable iff (!aresetn)
    state == HMS_FULL_HALT |-> !periph_clk_en && !cpu_run)
    else $error("peripherals clocked in full halt");
  chk_wdg_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_exec && !osc_irq_enable && watchdog_active && !option[OPT_WDG_HALT] |=> watchdog_reset && cpu_run)
    else $error("watchdog halt option not honoured");
  chk_release_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    state == HMS_SETTLE && settle_done |=> cpu_run && fetch_reset_vector == $past(settle_from_reset))
    else $error("release after settling wrong");
  chk_osc_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    state == HMS_FULL_HALT && (wake_reset || halt_wake_irq) |=> state == HMS_SETTLE && osc_enable && !cpu_run)
    else $error("full halt wake did not restart oscillator");
  chk_sleep_clocks: assert property (@(posedge aclk) disable iff (!aresetn)
    state == HMS_TIMED_SLEEP |-> osc_enable && timebase_clk_en && !periph_clk_en && !cpu_run)
    else $error("timed sleep clocking wrong");
  chk_halt_opcode: assert property (@(posedge aclk) disable iff (!aresetn)
    opcode_valid && opcode != HALT_OPCODE && cpu_run |=> cpu_run)
    else $error("non halt opcode stopped the cpu");
  chk_reset_settle: assert property (@(posedge aclk) disable iff (!aresetn)
    state == HMS_TIMED_SLEEP && wake_reset |=> state == HMS_SETTLE && !cpu_run)
    else $error("reset wake from timed sleep skipped settling");
  chk_push_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_service && cpu_run && !halt_exec |=> cc_push && mask_level == $past(irq_level))
    else $error("service did not push or set level");
  chk_mask_pop: assert property (@(posedge aclk) disable iff (!aresetn)
    cc_pop && !halt_exec && !(irq_service && cpu_run) |=> mask_level == $past(cc_popped_level))
    else $error("pop did not restore level");
  chk_irq_output: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(irq_stat & $past(irq_mask)))
    else $error("irq line disagrees with status and mask");
  chk_wake_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_wake |=> irq_stat[IRQ_WAKE])
    else $error("wake event not recorded");
  chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule // hms_sequencer

/* tb/hms_cpu_model.sv */
// cpu core, timebase and wake sources seen from the sequencer
`timescale 1ns/1ns
module hms_cpu_model (
  // clock
  input wire logic aclk,
  // towards the sequencer
  output logic opcode_valid,
  output logic [7:0] opcode,
  output logic wake_reset,
  output logic timebase_irq,
  output logic halt_wake_irq,
  output logic irq_service,
  output logic [1:0] irq_level,
  output logic cc_pop,
  output logic [1:0] cc_popped_level
);
  initial begin
    {opcode_valid, wake_reset, timebase_irq, halt_wake_irq, irq_service, cc_pop} = '0;
    {opcode, irq_level, cc_popped_level} = '0;
  end
  // software set up the wake pin and cleared stale flags, so nothing fires early
  // k: 0 opcode, 1 timebase, 2 halt wake, 3 reset wake, 4 service, 5 pop
  task automatic pulse(input int k, input logic [7:0] v);
    @(posedge aclk);
    case (k)
      0: begin
        opcode_valid <= 1'b1;
        opcode <= v;
      end
      1: timebase_irq <= 1'b1;
      2: halt_wake_irq <= 1'b1;
      3: wake_reset <= 1'b1;
      4: begin
        irq_service <= 1'b1;
        irq_level <= v[1:0];
      end
      default: begin
        cc_pop <= 1'b1;
        cc_popped_level <= v[1:0];
      end
    endcase
    @(posedge aclk);
    {opcode_valid, wake_reset, timebase_irq, halt_wake_irq, irq_service, cc_pop} <= '0;
    // idle opcode bus does not keep the old byte
    opcode <= ~v;
  endtask
endmodule // hms_cpu_model

/* tb/halt_mode_sequencer_tb.sv */
// self-checking bench for the halt mode sequencer
`timescale 1ns/1ns
module halt_mode_sequencer_tb;
  import hms_pkg::*;
  localparam int SD = 4;
  localparam int LD = 8;
  logic aclk = 0, aresetn = 0, watchdog_active = 0;
  logic opcode_valid, wake_reset, timebase_irq, halt_wake_irq, irq_service, cc_pop;
  logic [7:0] opcode;
  logic [1:0] irq_level, cc_popped_level, mask_level, s_axi_bresp, s_axi_rresp;
  logic cc_push, cpu_run, fetch_reset_vector, osc_enable, timebase_clk_en, periph_clk_en, watchdog_reset, irq;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, v;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int frv_seen = 0, wdg_seen = 0, push_seen = 0;
  logic [33:0] q[$];
  int mismatches = 0, samples_checked = 0;
  always #20 aclk = ~aclk;
  hms_cpu_model cpu (.aclk, .opcode_valid, .opcode, .wake_reset, .timebase_irq, .halt_wake_irq,
    .irq_service, .irq_level, .cc_pop, .cc_popped_level);
  hms_sequencer #(.SHORT_DELAY(SD), .LONG_DELAY(LD)) uut (.aclk, .aresetn, .opcode_valid, .opcode,
    .wake_reset, .timebase_irq, .halt_wake_irq, .watchdog_active, .irq_service, .irq_level, .cc_pop,
    .cc_popped_level, .mask_level, .cc_push, .cpu_run, .fetch_reset_vector, .osc_enable,
    .timebase_clk_en, .periph_clk_en, .watchdog_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq);
  task automatic end_sim;
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one bus transfer; the expected response goes on the queue for the monitor
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    bit ta, tw, tr;
    int n;
    q.push_back(e);
    @(posedge aclk);
    if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_bready && s_axi_bvalid || s_axi_rready && s_axi_rvalid;
      @(posedge aclk);
      if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) begin
        {s_axi_bready, s_axi_rready} <= 2'b00;
        break;
      end
    end
    if (n == 40) begin
      mismatches++;
      end_sim();
    end
  endtask
  // counts cycles from the wake event until the cpu runs again
  task automatic settle(input int k, input int d);
    int n;
    cpu.pulse(k, 8'h00);
    for (n = 1; n < 60; n++) begin
      @(negedge aclk);
      if (n == 1) cmp(osc_enable, 1);
      if (cpu_run === 1'b1) break;
    end
    cmp(n == d + 1, 1);
  endtask
  // two edges so that a pulse launched at entry has reached the event counters
  task automatic halt;
    cpu.pulse(0, HALT_OPCODE);
    repeat (2) @(negedge aclk);
  endtask
  always @(negedge aclk)
    if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready)
      cmp(s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, q.pop_front());
  always @(posedge aclk) begin
    if (fetch_reset_vector) frv_seen <= frv_seen + 1;
    if (watchdog_reset) wdg_seen <= wdg_seen + 1;
    if (cc_push) push_seen <= push_seen + 1;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hcc3ef330));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, OFF_OPTION, 0, 34'h0);
    bus(0, 8'h14, 0, {RESP_SLVERR, 32'h0});
    bus(1, 8'h14, 0, {RESP_SLVERR, 32'h0});
    // a write with byte lane 0 disabled must leave the control bit alone
    s_axi_wstrb <= 4'h0;
    bus(1, OFF_CTRL, 1, 34'h0);
    s_axi_wstrb <= 4'hf;
    bus(0, OFF_CTRL, 0, 34'h0);
    halt();
    cmp({cpu_run, mask_level, periph_clk_en, osc_enable}, {3'b010, 2'b00});
    settle(2, SD);
    cmp(frv_seen, 0);
    // oie stays set through every timebase wake below
    bus(1, OFF_CTRL, 1, 34'h0);
    watchdog_active <= 1'b1;
    halt();
    cmp({cpu_run, mask_level, periph_clk_en, osc_enable, timebase_clk_en}, 6'b010011);
    cpu.pulse(2, 8'h00);
    @(negedge aclk);
    cmp(cpu_run, 0);
    settle(1, 0);
    cmp(wdg_seen, 0);
    bus(1, OFF_OPTION, 1, 34'h0);
    halt();
    settle(3, LD);
    @(negedge aclk);
    cmp(frv_seen, 1);
    bus(1, OFF_CTRL, 0, 34'h0);
    halt();
    cmp({cpu_run, wdg_seen == 1}, 2'b11);
    bus(1, OFF_OPTION, 3, 34'h0);
    halt();
    cmp({cpu_run, wdg_seen == 1}, 2'b01);
    settle(2, LD);
    // random bytes other than the halt opcode never stop the cpu
    repeat (8) begin
      v = 8'($urandom);
      if (v == HALT_OPCODE) v = 8'h00;
      cpu.pulse(0, v);
      @(negedge aclk);
      cmp(cpu_run, 1);
    end
    cpu.pulse(4, 8'h01);
    repeat (2) @(negedge aclk);
    cmp({push_seen == 1, mask_level}, 3'b101);
    cpu.pulse(5, 8'h03);
    @(negedge aclk);
    cmp(mask_level, 3);
    // a mask bit of one lets its status bit drive the line
    cmp(irq, 0);
    bus(1, OFF_IRQ_MASK, 7, 34'h0);
    @(negedge aclk);
    cmp(irq, 1);
    bus(0, OFF_IRQ_STAT, 0, 34'h7);
    bus(1, OFF_IRQ_STAT, 7, 34'h0);
    @(negedge aclk);
    cmp(irq, 0);
    bus(0, OFF_IRQ_STAT, 0, 34'h0);
    bus(0, OFF_IRQ_MASK, 0, 34'h7);
    bus(0, OFF_STATUS, 0, 34'h7);
    end_sim();
  end
endmodule // halt_mode_sequencer_tb
